/* File: aic_consts.vh */
// Constants for the analog input comparator block
`ifndef AIC_CONSTS_VH
`define AIC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AIC_OFS_CTRL 8'h00
`define AIC_OFS_ALLOW 8'h04
`define AIC_OFS_TOL 8'h08
`define AIC_OFS_LIMIT 8'h0C
`define AIC_OFS_STATUS 8'h10
`define AIC_CH_BASE 3'h1
`define AIC_CH_LAST 3'h4
`define AIC_CH_SCALE 5'h00
`define AIC_CH_WIN 5'h04
`define AIC_CH_WHYS 5'h08
`define AIC_CH_THR 5'h0C
`define AIC_CH_THYS 5'h10
`define AIC_CH_EVAL 5'h14
`define AIC_CH_CFG 5'h18

// ----------------------------------------
// Layout codes in CTRL[1:0], other CTRL bits
// ----------------------------------------
`define AIC_LAY_SINGLE 2'h0
`define AIC_LAY_PAIR12 2'h1
`define AIC_LAY_PAIR34 2'h2
`define AIC_CTRL_DIFF 2

// ----------------------------------------
// Channel config bits
// ----------------------------------------
`define AIC_CFG_WIN 0
`define AIC_CFG_THR1 1
`define AIC_CFG_THR2 2
`define AIC_CFG_VOLT 3
`define AIC_CFG_ZERO 4
`define AIC_CFG_ERR 5
`define AIC_CFG_W 6

// ----------------------------------------
// Raw code levels (full scale = 20 mA or 10 V)
// ----------------------------------------
`define AIC_RAW_4MA 16'h3333
`define AIC_RAW_BROKEN 16'h0CCC
`define AIC_SPAN_MUL 3'h5
`define AIC_SPAN_SHIFT 2
`define AIC_ENG_SHIFT 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AIC_RST_LIMIT 32'hFFFF_0000
`define AIC_RST_WORD 32'h0000_0000

`endif

/* File: aic_analog_inputs.v */
// Four-channel analog input scaling, coherence and comparators with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "aic_consts.vh"

module aic_analog_inputs #(
   parameter RAW_W = 16,
   parameter NCH = 4
)(
   // Clock and reset
   input wire core_clk_i,
   input wire nrst_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Converter samples, same clock domain
   input wire sample_valid_i,
   input wire [NCH*RAW_W-1:0] raw_i,
   // Logic outputs
   output wire [NCH-1:0] first_compare_output_o,
   output wire [NCH-1:0] second_compare_output_o,
   output wire [NCH-1:0] error_o,
   output wire incoherent_o
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [2:0] ctrl_reg;
   reg [15:0] allow_reg;
   reg [31:0] tol_reg;
   reg [31:0] limit_reg;
   reg [31:0] scale_reg [0:NCH-1];
   reg [31:0] win_reg [0:NCH-1];
   reg [15:0] whys_reg [0:NCH-1];
   reg [31:0] thr_reg [0:NCH-1];
   reg [31:0] thys_reg [0:NCH-1];
   reg [`AIC_CFG_W-1:0] cfg_reg [0:NCH-1];

   reg upd_reg;
   reg [15:0] eng_reg [0:NCH-1];
   reg [NCH-1:0] diag_reg;
   reg [NCH-1:0] win_st_reg;
   reg [NCH-1:0] t1_st_reg;
   reg [NCH-1:0] t2_st_reg;
   reg dev_over_reg;
   reg [31:0] coh_cnt_reg;
   reg incoh_reg;

   wire [1:0] layout;
   wire pair_on;
   wire [2:0] ch_sel;
   wire [1:0] ch_idx;
   wire [4:0] ch_ofs;
   wire ch_hit;
   wire glob_hit;
   wire apb_wr;
   wire apb_acc;
   wire mapped;
   integer i;

   // Illegal layout code falls back to all single
   assign layout = (ctrl_reg[1:0] == `AIC_LAY_PAIR12 ||
                    ctrl_reg[1:0] == `AIC_LAY_PAIR34) ? ctrl_reg[1:0] : `AIC_LAY_SINGLE;
   assign pair_on = (layout != `AIC_LAY_SINGLE);

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign ch_sel = paddr_i[7:5];
   // Channel windows 1 to 4 fold onto array indices 0 to 3
   assign ch_idx = ch_sel[1:0] - 2'h1;
   assign ch_ofs = paddr_i[4:0];
   assign ch_hit = (ch_sel >= `AIC_CH_BASE) && (ch_sel <= `AIC_CH_LAST) &&
                   (ch_ofs <= `AIC_CH_CFG) && (paddr_i[1:0] == 2'h0);
   assign glob_hit = (paddr_i <= `AIC_OFS_STATUS) && (paddr_i[1:0] == 2'h0);
   assign mapped = ch_hit || glob_hit;
   assign apb_acc = psel_i && penable_i;
   assign apb_wr = apb_acc && pwrite_i;
   // No wait states: each access ends at its first access edge
   assign pready_o = 1'b1;
   // Writes to read-only words are dropped silently; only holes raise an error
   assign pslverr_o = apb_acc && !mapped;

   always @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_reg <= 3'h0;
         allow_reg <= 16'h0000;
         tol_reg <= `AIC_RST_WORD;
         limit_reg <= `AIC_RST_LIMIT;
         for (i = 0; i < NCH; i = i + 1)
         begin
            scale_reg[i] <= `AIC_RST_WORD;
            win_reg[i] <= `AIC_RST_WORD;
            whys_reg[i] <= 16'h0000;
            thr_reg[i] <= `AIC_RST_WORD;
            thys_reg[i] <= `AIC_RST_WORD;
            cfg_reg[i] <= {`AIC_CFG_W{1'b0}};
         end
      end
      else if (apb_wr && glob_hit)
      begin
         case (paddr_i)
            `AIC_OFS_CTRL: ctrl_reg <= pwdata_i[2:0];
            `AIC_OFS_ALLOW: allow_reg <= pwdata_i[15:0];
            `AIC_OFS_TOL: tol_reg <= pwdata_i;
            `AIC_OFS_LIMIT: limit_reg <= pwdata_i;
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
      else if (apb_wr && ch_hit)
      begin
         case (ch_ofs)
            `AIC_CH_SCALE: scale_reg[ch_idx] <= pwdata_i;
            `AIC_CH_WIN: win_reg[ch_idx] <= pwdata_i;
            `AIC_CH_WHYS: whys_reg[ch_idx] <= pwdata_i[15:0];
            `AIC_CH_THR: thr_reg[ch_idx] <= pwdata_i;
            `AIC_CH_THYS: thys_reg[ch_idx] <= pwdata_i;
            `AIC_CH_CFG: cfg_reg[ch_idx] <= pwdata_i[`AIC_CFG_W-1:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Read mux, combinational; APB samples it at the access edge
   always @*
   begin
      prdata_o = 32'h0000_0000;
      if (glob_hit)
      begin
         case (paddr_i)
            `AIC_OFS_CTRL: prdata_o = {29'h0, ctrl_reg};
            `AIC_OFS_ALLOW: prdata_o = {16'h0, allow_reg};
            `AIC_OFS_TOL: prdata_o = tol_reg;
            `AIC_OFS_LIMIT: prdata_o = limit_reg;
            `AIC_OFS_STATUS: prdata_o = {15'h0000, incoh_reg, error_o,
                                         diag_reg, second_compare_output_o,
                                         first_compare_output_o};
            default: prdata_o = 32'h0000_0000;
         endcase
      end
      else if (ch_hit)
      begin
         case (ch_ofs)
            `AIC_CH_SCALE: prdata_o = scale_reg[ch_idx];
            `AIC_CH_WIN: prdata_o = win_reg[ch_idx];
            `AIC_CH_WHYS: prdata_o = {16'h0, whys_reg[ch_idx]};
            `AIC_CH_THR: prdata_o = thr_reg[ch_idx];
            `AIC_CH_THYS: prdata_o = thys_reg[ch_idx];
            `AIC_CH_EVAL: prdata_o = {{16{eng_reg[ch_idx][15]}}, eng_reg[ch_idx]};
            `AIC_CH_CFG: prdata_o = {{(32-`AIC_CFG_W){1'b0}}, cfg_reg[ch_idx]};
            default: prdata_o = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Per-channel scaling, diagnosis, comparators
   // ----------------------------------------
   // Comparators run one cycle after the sample so they see registered values
   always @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         upd_reg <= 1'b0;
      else
         upd_reg <= sample_valid_i;
   end

   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1)
      begin : g_ch
         localparam PREV = (c == 0) ? 0 : c - 1;
         wire [RAW_W-1:0] raw;
         wire second;
         wire [31:0] scl;
         wire zero_lo;
         wire [RAW_W-1:0] lo_code;
         wire [RAW_W:0] norm0;
         wire [RAW_W+3:0] norm1;
         wire [RAW_W:0] norm;
         wire signed [16:0] span;
         wire signed [34:0] prod;
         wire signed [17:0] eng_w;
         wire [15:0] eng_sat;
         wire signed [17:0] m;
         wire signed [17:0] hi;
         wire signed [17:0] lo;
         wire signed [17:0] hy;
         wire signed [17:0] t1;
         wire signed [17:0] h1;
         wire signed [17:0] t2;
         wire signed [17:0] h2;
         wire [`AIC_CFG_W-1:0] cfg;
         wire min_diag;
         wire max_diag;
         wire broken;
         wire win_next;
         wire t1_next;
         wire t2_next;

         assign raw = raw_i[c*RAW_W +: RAW_W];
         assign cfg = cfg_reg[c];
         // Second member of a pair has no comparators of its own
         assign second = ((layout == `AIC_LAY_PAIR12) && (c == 1)) ||
                         ((layout == `AIC_LAY_PAIR34) && (c == 3));
         // Identical sensors share the first member's scale
         assign scl = (second && !ctrl_reg[`AIC_CTRL_DIFF]) ?
                      scale_reg[PREV] : scale_reg[c];
         assign zero_lo = cfg[`AIC_CFG_VOLT] || cfg[`AIC_CFG_ZERO];
         assign lo_code = zero_lo ? {RAW_W{1'b0}} : `AIC_RAW_4MA;
         assign norm0 = (raw > lo_code) ? {1'b0, raw - lo_code} : {(RAW_W+1){1'b0}};
         // 4-20 mA spans four fifths of full code, stretched by 5/4
         assign norm1 = zero_lo ? {3'h0, norm0} :
                        ((norm0 * `AIC_SPAN_MUL) >> `AIC_SPAN_SHIFT);
         assign norm = (norm1 > {3'h0, {RAW_W{1'b1}}}) ? {1'b0, {RAW_W{1'b1}}} :
                       norm1[RAW_W:0];
         assign span = $signed({scl[31], scl[31:16]}) - $signed({scl[15], scl[15:0]});
         assign prod = $signed({1'b0, norm}) * span;
         // Product magnitude stays below 2^32, so bit 33 already holds its sign
         assign eng_w = $signed({{2{scl[15]}}, scl[15:0]}) +
                        $signed(prod[33:`AIC_ENG_SHIFT]);
         assign eng_sat = (eng_w > $signed(18'sh07FFF)) ? 16'h7FFF :
                          (eng_w < $signed(18'sh38000)) ? 16'h8000 : eng_w[15:0];

         // Minimum check dropped on ZERO ranges only; broken-cable check dropped on ZERO and VOLT ranges
         assign min_diag = !cfg[`AIC_CFG_ZERO] && (raw < limit_reg[15:0]);
         assign max_diag = raw > limit_reg[31:16];
         assign broken = !zero_lo && (raw < `AIC_RAW_BROKEN);

         always @(posedge core_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               eng_reg[c] <= 16'h0000;
               diag_reg[c] <= 1'b0;
            end
            else if (sample_valid_i)
            begin
               eng_reg[c] <= eng_sat;
               diag_reg[c] <= min_diag || max_diag || broken;
            end
         end

         assign m = {{2{eng_reg[c][15]}}, eng_reg[c]};
         assign hi = {{2{win_reg[c][31]}}, win_reg[c][31:16]};
         assign lo = {{2{win_reg[c][15]}}, win_reg[c][15:0]};
         assign hy = {{2{whys_reg[c][15]}}, whys_reg[c]};
         assign t1 = {{2{thr_reg[c][15]}}, thr_reg[c][15:0]};
         assign t2 = {{2{thr_reg[c][31]}}, thr_reg[c][31:16]};
         assign h1 = {{2{thys_reg[c][15]}}, thys_reg[c][15:0]};
         assign h2 = {{2{thys_reg[c][31]}}, thys_reg[c][31:16]};

         assign win_next = win_st_reg[c] ?
                           ((m < hi) && (m > lo - hy)) :
                           ((m < hi - hy) && (m > lo));
         assign t1_next = t1_st_reg[c] ? !(m < t1 - h1) : (m > t1);
         assign t2_next = t2_st_reg[c] ? !(m < t2 - h2) : (m > t2);

         always @(posedge core_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               win_st_reg[c] <= 1'b0;
               t1_st_reg[c] <= 1'b0;
               t2_st_reg[c] <= 1'b0;
            end
            else if (second)
            begin
               win_st_reg[c] <= 1'b0;
               t1_st_reg[c] <= 1'b0;
               t2_st_reg[c] <= 1'b0;
            end
            else if (upd_reg)
            begin
               win_st_reg[c] <= cfg[`AIC_CFG_WIN] && win_next;
               // Window mode locks out both thresholds
               t1_st_reg[c] <= !cfg[`AIC_CFG_WIN] && cfg[`AIC_CFG_THR1] && t1_next;
               t2_st_reg[c] <= !cfg[`AIC_CFG_WIN] && cfg[`AIC_CFG_THR2] && t2_next;
            end
         end

         assign first_compare_output_o[c] = cfg[`AIC_CFG_WIN] ?
                                            win_st_reg[c] : t1_st_reg[c];
         assign second_compare_output_o[c] = t2_st_reg[c];
         assign error_o[c] = cfg[`AIC_CFG_ERR] && (diag_reg[c] ||
                             (incoh_reg && pair_on &&
                              ((layout == `AIC_LAY_PAIR12) == (c < 2))));
      end
   endgenerate

   // ----------------------------------------
   // Pair coherence timing
   // ----------------------------------------
   wire signed [16:0] pa;
   wire signed [16:0] pb;
   wire signed [16:0] pdiff;
   wire [16:0] pabs;

   // Single layout still feeds pair 1-2 here; pair_on masks the result
   assign pa = (layout == `AIC_LAY_PAIR34) ? {eng_reg[2][15], eng_reg[2]} :
               {eng_reg[0][15], eng_reg[0]};
   assign pb = (layout == `AIC_LAY_PAIR34) ? {eng_reg[3][15], eng_reg[3]} :
               {eng_reg[1][15], eng_reg[1]};
   assign pdiff = pa - pb;
   assign pabs = pdiff[16] ? (17'h0 - pdiff) : pdiff;

   always @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dev_over_reg <= 1'b0;
         coh_cnt_reg <= 32'h0000_0000;
         incoh_reg <= 1'b0;
      end
      else
      begin
         if (upd_reg)
            dev_over_reg <= pair_on && (pabs > {1'b0, allow_reg});
         // Counter saturates one past the tolerance, so no wrap unless TOL is all ones
         if (!pair_on || !dev_over_reg)
            coh_cnt_reg <= 32'h0000_0000;
         else if (coh_cnt_reg <= tol_reg)
            coh_cnt_reg <= coh_cnt_reg + 32'h0000_0001;
         // Flag drops one cycle after the deviation clears, pair mode ends or TOL rises above the count
         incoh_reg <= pair_on && dev_over_reg && (coh_cnt_reg > tol_reg);
      end
   end

   assign incoherent_o = incoh_reg;

endmodule
`default_nettype wire

/* File: aic_conv_model.sv */
// Converter model that hands sample sets to the comparator block
`timescale 1ns/1ps
`default_nettype none
module aic_conv_model (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Request from the bench
   input wire logic go_i,
   input wire logic [63:0] word_i,
   // Converter side
   output logic sample_valid_o,
   output logic [63:0] raw_o
);
   always @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sample_valid_o <= 1'b0;
         raw_o <= 64'h0;
      end
      else if (go_i)
      begin
         sample_valid_o <= 1'b1;
         raw_o <= word_i;
      end
      else
      begin
         // Stale codes toggle so a late capture shows up
         sample_valid_o <= 1'b0;
         raw_o <= ~raw_o;
      end
   end
endmodule
`default_nettype wire

/* File: aic_analog_inputs_chk.sv */
// Port checker for the analog input comparator block
`timescale 1ns/1ps
`default_nettype none
module aic_analog_inputs_chk #(
   parameter RAW_W = 16,
   parameter NCH = 4
)(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Samples and logic outputs
   input wire logic sample_valid_i,
   input wire logic [NCH*RAW_W-1:0] raw_i,
   input wire logic [NCH-1:0] first_compare_output_o,
   input wire logic [NCH-1:0] second_compare_output_o,
   input wire logic [NCH-1:0] error_o,
   input wire logic incoherent_o
);
   wire acc;
   wire unmapped;
   assign acc = psel_i && penable_i;
   assign unmapped = (paddr_i[1:0] != 2'h0) || (paddr_i >= 8'hA0) ||
      (paddr_i > 8'h10 && paddr_i < 8'h20) || (paddr_i >= 8'h20 && paddr_i[4:0] == 5'h1C);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   zero_wait_a: assert property (psel_i |-> pready_o) else $error("pready low");
   err_access_a: assert property (pslverr_o |-> acc) else $error("pslverr outside access");
   unmapped_err_a: assert property (acc && unmapped |-> pslverr_o) else $error("hole accepted");
   mapped_ok_a: assert property (acc && !unmapped |-> !pslverr_o) else $error("mapped refused");
   hole_read_a: assert property (acc && unmapped && !pwrite_i |-> prdata_o == 32'h0)
      else $error("hole read not zero");
   first_compare_output_timing_a: assert property ($changed(first_compare_output_o) |->
      $past(sample_valid_i, 2)) else $error("first output moved without sample");
   second_compare_output_timing_a: assert property ($changed(second_compare_output_o) |->
      $past(sample_valid_i, 2)) else $error("second output moved without sample");
   error_cause_a: assert property ($changed(error_o) |-> $past(sample_valid_i) ||
      $past(sample_valid_i, 2) || $changed(incoherent_o) || $past(acc && pwrite_i))
      else $error("error output moved without cause");
   reset_quiet_a: assert property ($rose(nrst_i) |-> first_compare_output_o == 4'h0 &&
      second_compare_output_o == 4'h0 && error_o == 4'h0 && !incoherent_o)
      else $error("outputs not cleared by reset");
   cover property ($rose(first_compare_output_o[0]));
   cover property ($rose(second_compare_output_o[1]));
   cover property ($rose(incoherent_o));
   cover property ($rose(error_o[2]));
endmodule
bind aic_analog_inputs aic_analog_inputs_chk #(.RAW_W(RAW_W), .NCH(NCH)) i_aic_analog_inputs_chk (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
   .raw_i(raw_i), .first_compare_output_o(first_compare_output_o),
   .second_compare_output_o(second_compare_output_o), .error_o(error_o),
   .incoherent_o(incoherent_o));
`default_nettype wire

/* File: aic_analog_inputs_tb.sv */
// Self-checking bench for the analog input comparator block
`timescale 1ns/1ps
`default_nettype none
module aic_analog_inputs_tb;
   logic core_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, err, go, sv, incoh;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [63:0] word, raw;
   logic [3:0] fo, so, eo;
   logic [39:0] rows [14];
   logic [39:0] setup [12];
   int fails, n_compared;
   aic_conv_model i_aic_conv_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .go_i(go),
      .word_i(word), .sample_valid_o(sv), .raw_o(raw));
   aic_analog_inputs i_aic_analog_inputs (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .sample_valid_i(sv), .raw_i(raw), .first_compare_output_o(fo),
      .second_compare_output_o(so), .error_o(eo), .incoherent_o(incoh));
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   task print_verdict;
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fails++;
         print_verdict();
      end
   endtask
   // Outputs settle one update after the sample edge
   task send(input logic [63:0] w);
      @(posedge core_clk_i);
      go <= 1'b1;
      word <= w;
      @(posedge core_clk_i);
      go <= 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask
   task wait_incoh(input logic lvl, input int exp_n);
      int n;
      n = 0;
      while (incoh !== lvl && n < 30)
      begin
         @(posedge core_clk_i);
         n++;
      end
      chk({31'h0, incoh}, {31'h0, lvl});
      chk(n, exp_n);
      if (n >= 30)
         print_verdict();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      // Measure, raw for ch2/ch3, expected {err3,err2,second_compare_output[1:0],first_compare_output[1:0]}
      rows = '{40'h0096800009, 40'h00BE00001B, 40'h00CDF0013A, 40'h00BE2FFF1A,
         40'h009630000B, 40'h005AF00009, 40'h004B800008, 40'h005F800008,
         40'h0064800008, 40'h0065800009, 40'h0028800000, 40'h0032800000,
         40'h0033800008, 40'h008D800009};
      setup = '{40'h2040000000, 40'h2400C80064, 40'h2800000014, 40'h380000001F,
         40'h4040000000, 40'h4C00320096, 40'h500005000A, 40'h580000001E,
         40'h7800000020, 40'h9800000030, 40'h0CF0003000, 40'h6040000000};
      nrst_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      go = 1'b0;
      word = 64'h0;
      fails = 0;
      n_compared = 0;
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      chk({19'h0, incoh, eo, so, fo}, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'hFFFF_0000);
      foreach (setup[k])
         apb(1'b1, setup[k][39:32], setup[k][31:0]);
      apb(1'b0, 8'h24, 32'h0);
      chk(q, 32'h00C8_0064);
      foreach (rows[k])
      begin
         send({rows[k][23:8], rows[k][23:8], rows[k][37:24], 2'b00, rows[k][37:24], 2'b00});
         chk({26'h0, eo[3:2], so[1:0], fo[1:0]}, {26'h0, rows[k][5:0]});
         apb(1'b0, 8'h34, 32'h0);
         chk(q, {16'h0, rows[k][39:24]});
      end
      apb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0000_0021);
      send({16'h0, 16'h3333, 32'h0});
      apb(1'b0, 8'h74, 32'h0);
      chk(q, 32'h0);
      send({16'h0, 16'hFFFF, 32'h0});
      apb(1'b0, 8'h74, 32'h0);
      chk(q, 32'h0000_3FFF);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(q, 32'h0);
      apb(1'b1, 8'h04, 32'h0000_000A);
      apb(1'b1, 8'h08, 32'h0000_0003);
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h38, 32'h0000_003F);
      send({32'h0, 16'h0258, 16'h0190});
      chk({31'h0, incoh}, 32'h0);
      wait_incoh(1'b1, 5);
      chk({30'h0, so[1], fo[1]}, 32'h0);
      chk({30'h0, eo[1:0]}, 32'h1);
      send({32'h0, 16'h0190, 16'h0190});
      wait_incoh(1'b0, 1);
      // Different sensors: second member converts with its own scale
      apb(1'b1, 8'h40, 32'h2000_0000);
      apb(1'b1, 8'h00, 32'h0000_0005);
      send({32'h0, 16'h0320, 16'h0190});
      apb(1'b0, 8'h54, 32'h0);
      chk(q, 32'h0000_0064);
      send({32'h0, 16'h04B0, 16'h0258});
      chk({28'h0, fo}, 32'h1);
      // Mid-run reset must clear live outputs and registers
      nrst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk({19'h0, incoh, eo, so, fo}, 32'h0);
      nrst_i <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
